// ===== testbench/prf_host_model.sv
// host model that issues read commands and takes the answers
`timescale 1ns/10ps
`default_nettype none
module prf_host (
	input  wire logic        i_mclk,
	input  wire logic        o_rd_valid,
	input  wire logic        o_rd_err,
	input  wire logic [15:0] o_rd_data,
	output logic             i_rd_req = 1'b0,
	output logic [7:0]       i_rd_cmd = 8'h00
);
	task automatic rd(input logic [7:0] c, output logic [15:0] d, output logic e);
		int n;
		n = 0;
		i_rd_req = 1'b1;
		i_rd_cmd = c;
		// the rising edge in between takes the request; the answer stands until the next one
		@(negedge i_mclk);
		i_rd_req = 1'b0;
		i_rd_cmd = ~c;
		while (o_rd_valid !== 1'b1 && n < 4) begin
			@(negedge i_mclk);
			n++;
		end
		d = (o_rd_valid === 1'b1) ? o_rd_data : 16'hxxxx;
		e = (o_rd_valid === 1'b1) ? o_rd_err : 1'bx;
		@(negedge i_mclk);
	endtask : rd
endmodule : prf_host
`default_nettype wire

// ===== testbench/prf_result_flag_regs_assertions.sv
// checker of the read port and event flags
`timescale 1ns/10ps
`default_nettype none
module prf_chk (
	input wire logic i_mclk, i_rst, i_meas_valid, i_sunlight_event, i_rd_req,
	input wire logic [prf_pkg::DATA_W-1:0] i_meas_data, i_thresh_high, i_thresh_low,
	input wire logic [7:0] i_rd_cmd,
	input wire logic [15:0] o_rd_data,
	input wire logic o_rd_valid, o_rd_err, o_sunlight_protect_event, o_approach_event,
	input wire logic o_recede_event
);
	import prf_pkg::*;
	default clocking @(posedge i_mclk); endclocking
	default disable iff (i_rst);
	wire rdf = i_rd_req && i_rd_cmd == CMD_FLAGS;
	result_word_a: assert property (
		i_meas_valid ##1 (i_rd_req && !i_meas_valid && i_rd_cmd == CMD_RESULT)
		|=> o_rd_data == {4'h0, $past(i_meas_data, 2)}) else $error("bad result");
	identity_word_a: assert property (
		i_rd_req && i_rd_cmd == CMD_IDENTITY |=> o_rd_data == IDENTITY_CODE) else $error("bad id");
	reserved_zero_a: assert property (
		rdf |=> o_rd_valid && (o_rd_data & 16'hECFF) == 16'h0000) else $error("bad reserved");
	flag_word_a: assert property (
		rdf |=> o_rd_data[12] == o_sunlight_protect_event
		&& o_rd_data[9:8] == {o_approach_event, o_recede_event}) else $error("bad flags");
	sun_flag_a: assert property (
		i_sunlight_event |-> ##2 o_sunlight_protect_event) else $error("no sun flag");
	approach_flag_a: assert property (
		i_meas_valid && i_meas_data > i_thresh_high |-> ##2 o_approach_event) else $error("no up");
	recede_flag_a: assert property (
		i_meas_valid && i_meas_data < i_thresh_low |-> ##2 o_recede_event) else $error("no down");
endmodule : prf_chk
bind prf_result_flag_regs prf_chk u_chk (.*);
`default_nettype wire

// ===== testbench/tb_proximity_result_flag_regs.sv
// bench of the result, flag and identity registers
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin n_mismatch++; $display("mismatch %0t read", $time); end end
module tb_proximity_result_flag_regs;
	import prf_pkg::*;
	logic i_mclk = 0, i_rst = 1, i_meas_valid = 0, i_sunlight_event = 0, i_rd_req;
	logic o_rd_valid, o_rd_err, o_sunlight_protect_event, o_approach_event, o_recede_event;
	logic [DATA_W-1:0] i_meas_data = 0, i_thresh_high = 0, i_thresh_low = 0, x;
	logic [7:0] i_rd_cmd;
	logic [15:0] o_rd_data, d;
	logic e, es = 0, ea = 0, er = 0;
	int n_mismatch = 0, checks = 0, cyc = 0;
	prf_result_flag_regs u_dut (.*);
	prf_host u_host (.*);
	always #50 i_mclk = ~i_mclk;
	always @(posedge i_mclk) if (++cyc == 2000) begin
		n_mismatch++;
		complete_run;
	end
	task automatic complete_run;
		if (n_mismatch == 0 && checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : complete_run
	task automatic meas(input logic [DATA_W-1:0] v, input logic s);
		i_meas_data = v;
		i_sunlight_event = s;
		i_meas_valid = 1;
		es |= s;
		ea |= v > i_thresh_high;
		er |= v < i_thresh_low;
		@(negedge i_mclk);
		i_meas_valid = 0;
		i_sunlight_event = 0;
	endtask : meas
	function automatic logic [15:0] fw(logic s, a, r);
		return {3'h0, s, 2'h0, a, r, 8'h00};
	endfunction : fw
	initial begin
		void'($urandom(32'h76c1));
		repeat (4) @(negedge i_mclk);
		i_rst = 0;
		for (int k = 0; k < 4; k++) begin
			u_host.rd(8'hF5 + 8'(k), d, e);
			`CHK(d, k == 1 ? IDENTITY_CODE : 16'h0000)
			`CHK(e, k > 1)
		end
		for (int k = 0; k < 24; k++) begin
			i_thresh_high = 12'($urandom);
			i_thresh_low = 12'($urandom);
			x = k == 0 ? i_thresh_high : k == 1 ? i_thresh_low : 12'($urandom);
			meas(x, 1'($urandom));
			u_host.rd(CMD_RESULT, d, e);
			`CHK(d, {4'h0, x})
			u_host.rd(CMD_FLAGS, d, e);
			`CHK(d, fw(es, ea, er))
			{es, ea, er} = 3'h0;
		end
		complete_run;
	end
endmodule : tb_proximity_result_flag_regs
`default_nettype wire

// ===== verilog/prf_event_flag.sv
// one sticky event flag: set wins over clear
`timescale 1ns/10ps
`default_nettype none
module prf_event_flag (
	// clock and reset
	input  wire logic i_mclk,
	input  wire logic i_rst,
	// set and clear
	input  wire logic i_set,
	input  wire logic i_clr,
	// flag
	output logic      o_flag
);
	typedef struct packed {
		logic flag;
	} prf_flag_st_t;

	prf_flag_st_t st;
	prf_flag_st_t next_st;

	always_comb begin
		next_st = st;
		if (i_clr) begin
			next_st.flag = 1'b0;
		end
		if (i_set) begin
			next_st.flag = 1'b1;
		end
	end

	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign o_flag = st.flag;
endmodule : prf_event_flag
`default_nettype wire

// ===== verilog/prf_pkg.sv
// package of command codes, field positions and reset values for the result and flag registers
package prf_pkg;
	// =========================================================
	// command codes
	localparam logic [7:0]  CMD_RESULT     = 8'hF4;
	localparam logic [7:0]  CMD_FLAGS      = 8'hF5;
	localparam logic [7:0]  CMD_IDENTITY   = 8'hF6;
	// =========================================================
	// field layout
	localparam int          DATA_W         = 12;
	localparam int          SUN_BIT        = 12;
	localparam int          APPROACH_BIT   = 9;
	localparam int          RECEDE_BIT     = 8;
	localparam logic [15:0] WORD_ZERO      = 16'h0000;
	localparam logic [11:0] RESULT_RESET   = 12'h000;
	// arbitrary identity value, not tied to any real part
	localparam logic [15:0] IDENTITY_CODE  = 16'hA5C3;
	// =========================================================
	// read answer state
	typedef enum logic [1:0] {
		PRF_IDLE = 2'b01,
		PRF_ANS  = 2'b10
	} prf_state_t;
endpackage : prf_pkg

// ===== verilog/prf_result_flag_regs.sv
// read-side result, event flag and identity registers of the proximity sensor
// Notes on behaviour
// - flag bit 12 shows sunlight protection event
// - flag bit 9 shows approach event
// - flag bit 8 shows recede event
// - reserved flag bits always read zero
// - identity word returns fixed device code
`timescale 1ns/10ps
`default_nettype none
module prf_result_flag_regs (
	// clock and reset
	input  wire logic                    i_mclk,
	input  wire logic                    i_rst,
	// measurement engine
	input  wire logic                    i_meas_valid,
	input  wire logic [prf_pkg::DATA_W-1:0] i_meas_data,
	input  wire logic                    i_sunlight_event,
	// thresholds from configuration registers
	input  wire logic [prf_pkg::DATA_W-1:0] i_thresh_high,
	input  wire logic [prf_pkg::DATA_W-1:0] i_thresh_low,
	// command port from the bus engine
	input  wire logic                    i_rd_req,
	input  wire logic [7:0]              i_rd_cmd,
	// read answer
	output logic                         o_rd_valid,
	output logic [15:0]                  o_rd_data,
	output logic                         o_rd_err,
	// event flag levels
	output logic                         o_sunlight_protect_event,
	output logic                         o_approach_event,
	output logic                         o_recede_event
);
	import prf_pkg::*;

	typedef struct packed {
		prf_state_t          state;
		logic [DATA_W-1:0]   result;
		logic [15:0]         rd_data;
		logic                rd_err;
		logic                sun;
		logic                appr;
		logic                rec;
	} prf_regs_st_t;

	prf_regs_st_t st;
	prf_regs_st_t next_st;

	// =========================================================
	// threshold compare and sticky flags
	logic set_appr;
	logic set_rec;
	logic clr_flags;
	logic f_sun;
	logic f_appr;
	logic f_rec;

	assign set_appr  = i_meas_valid && (i_meas_data > i_thresh_high);
	assign set_rec   = i_meas_valid && (i_meas_data < i_thresh_low);
	// reading the flag word clears the pending events
	assign clr_flags = i_rd_req && (i_rd_cmd == CMD_FLAGS);

	prf_event_flag u_sun (
		.i_mclk (i_mclk),
		.i_rst  (i_rst),
		.i_set  (i_sunlight_event),
		.i_clr  (clr_flags),
		.o_flag (f_sun)
	);
	prf_event_flag u_appr (
		.i_mclk (i_mclk),
		.i_rst  (i_rst),
		.i_set  (set_appr),
		.i_clr  (clr_flags),
		.o_flag (f_appr)
	);
	prf_event_flag u_rec (
		.i_mclk (i_mclk),
		.i_rst  (i_rst),
		.i_set  (set_rec),
		.i_clr  (clr_flags),
		.o_flag (f_rec)
	);

	// =========================================================
	// read decode
	always_comb begin
		next_st         = st;
		next_st.sun     = f_sun;
		next_st.appr    = f_appr;
		next_st.rec     = f_rec;
		next_st.state   = PRF_IDLE;
		next_st.rd_err  = 1'b0;
		if (i_meas_valid) begin
			next_st.result = i_meas_data;
		end
		if (i_rd_req) begin
			next_st.state   = PRF_ANS;
			next_st.rd_data = WORD_ZERO;
			case (i_rd_cmd)
				CMD_RESULT: begin
					next_st.rd_data[DATA_W-1:0] = st.result;
				end
				CMD_FLAGS: begin
					// reserved bits stay zero
					next_st.rd_data               = WORD_ZERO;
					next_st.rd_data[SUN_BIT]      = f_sun;
					next_st.rd_data[APPROACH_BIT] = f_appr;
					next_st.rd_data[RECEDE_BIT]   = f_rec;
				end
				CMD_IDENTITY: begin
					next_st.rd_data = IDENTITY_CODE;
				end
				default: begin
					next_st.rd_err = 1'b1;
				end
			endcase
		end
	end

	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			st         <= '0;
			st.state   <= PRF_IDLE;
			st.result  <= RESULT_RESET;
			st.rd_data <= WORD_ZERO;
		end else begin
			st <= next_st;
		end
	end

	assign o_rd_valid               = (st.state == PRF_ANS);
	assign o_rd_data                = st.rd_data;
	assign o_rd_err                 = st.rd_err;
	assign o_sunlight_protect_event = st.sun;
	assign o_approach_event         = st.appr;
	assign o_recede_event           = st.rec;
endmodule : prf_result_flag_regs
`default_nettype wire
